/* File: dfc_pkg.sv */
// Package for the dual-bank flash bus controller: timing, pin bundle, commands
package dfc_pkg;

	// Clock rate
	localparam int CLK_PERIOD_NS = 10;

	// Pin timing figures in ns (plain defaults, device part not fixed here)
	localparam int ACCESS_NS          = 90;   // Address access time
	localparam int SELECT_ACCESS_NS   = 90;   // Select access time
	localparam int WRITE_PULSE_NS     = 35;   // Write strobe low time
	localparam int WRITE_HIGH_NS      = 30;   // Write strobe high time
	localparam int CLEAR_PULSE_MIN_NS = 500;  // Clear pulse least width
	localparam int CLEAR_RECOVERY_NS  = 50;   // Clear release recovery
	localparam int SLEEP_EXTRA_NS     = 30;   // Added to access time for sleep entry

	// Least times round up to whole cycles
	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	localparam int ACCESS_CYC   = cyc_up(ACCESS_NS);
	localparam int SELECT_CYC   = cyc_up(SELECT_ACCESS_NS);
	localparam int WPULSE_CYC   = cyc_up(WRITE_PULSE_NS);
	localparam int WHIGH_CYC    = cyc_up(WRITE_HIGH_NS);
	localparam int CLEAR_CYC    = cyc_up(CLEAR_PULSE_MIN_NS);
	localparam int RECOVERY_CYC = cyc_up(CLEAR_RECOVERY_NS);
	localparam int SLEEP_CYC    = cyc_up(ACCESS_NS + SLEEP_EXTRA_NS);

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// Host operations
	typedef enum logic [2:0] {
		DFC_OP_READ  = 3'h0,
		DFC_OP_WRITE = 3'h1,
		DFC_OP_CLEAR = 3'h2
	} dfc_op_e;

	// Request from the user side
	typedef struct packed {
		dfc_op_e             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
		logic                byte_mode;
		logic                accel;
	} dfc_req_s;

	// Control pins toward the flash, active low where named so
	typedef struct packed {
		logic select_n;
		logic gate_n;
		logic write_n;
		logic clear_n;
		logic width_word;
	} dfc_ctl_s;

	// Sequencer states
	typedef enum logic [5:0] {
		DFC_ST_IDLE   = 6'b000001,
		DFC_ST_RD     = 6'b000010,
		DFC_ST_WLOW   = 6'b000100,
		DFC_ST_WHIGH  = 6'b001000,
		DFC_ST_CLR    = 6'b010000,
		DFC_ST_RECOV  = 6'b100000
	} dfc_state_e;

endpackage : dfc_pkg

/* File: dfc_host.sv */
// Host-side bus controller that drives a dual-bank asynchronous flash
module dfc_host
	import dfc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire dfc_req_s          req,
	input  wire logic              req_valid,
	output logic                   req_ready,
	output logic [DATA_W-1:0]      rdata,
	output logic                   rdata_valid,
	output logic                   clear_redo,
	output dfc_ctl_s               ctl,
	output logic                   accel_level,
	output logic [ADDR_W-1:0]      flash_addr,
	output logic [DATA_W-1:0]      dq_out,
	output logic                   dq_oe_n,
	input  wire logic [DATA_W-1:0] dq_in,
	input  wire logic              done_flag
);

	dfc_state_e       state;
	logic [CNT_W-1:0] cnt;
	logic [DATA_W-1:0] dq_s1, dq_s2;
	logic             done_s1, done_s2;
	logic             busy_seen;

	// Two synchroniser flops delay the data and done pins before the sequencer sees them
	localparam logic [CNT_W-1:0] SYNC_EXTRA = 8'h02;

	// Pins from the flash pass two flops before use
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dq_s1   <= 16'h0000;
			dq_s2   <= 16'h0000;
			done_s1 <= 1'h1;
			done_s2 <= 1'h1;
		end else begin
			dq_s1   <= dq_in;
			dq_s2   <= dq_s1;
			done_s1 <= done_flag;
			done_s2 <= done_s1;
		end
	end

	// Cycle counter loaded on each timed state entry
	function automatic logic [CNT_W-1:0] ld(input int c);
		return CNT_W'(c - 1);
	endfunction : ld

	// Sequencer; counter zero marks end of each timed phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= DFC_ST_IDLE;
			cnt   <= CNT_ZERO;
		end else begin
			case (state)
				DFC_ST_IDLE: begin
					if (req_valid) begin
						case (req.op)
							DFC_OP_READ: begin
								state <= DFC_ST_RD;
								cnt   <= ld((SELECT_CYC > ACCESS_CYC) ? SELECT_CYC : ACCESS_CYC) + SYNC_EXTRA;
							end
							DFC_OP_WRITE: begin
								state <= DFC_ST_WLOW;
								cnt   <= ld(WPULSE_CYC);
							end
							default: begin
								state <= DFC_ST_CLR;
								cnt   <= ld(CLEAR_CYC);
							end
						endcase
					end
				end
				DFC_ST_RD: begin
					if (cnt == CNT_ZERO) state <= DFC_ST_IDLE;
					else cnt <= cnt - CNT_W'(1);
				end
				DFC_ST_WLOW: begin
					if (cnt == CNT_ZERO) begin
						state <= DFC_ST_WHIGH;
						cnt   <= ld(WHIGH_CYC);
					end else cnt <= cnt - CNT_W'(1);
				end
				DFC_ST_WHIGH: begin
					if (cnt == CNT_ZERO) state <= DFC_ST_IDLE;
					else cnt <= cnt - CNT_W'(1);
				end
				DFC_ST_CLR: begin
					if (cnt == CNT_ZERO) begin
						state <= DFC_ST_RECOV;
						cnt   <= ld(RECOVERY_CYC) + SYNC_EXTRA;
					end else cnt <= cnt - CNT_W'(1);
				end
				DFC_ST_RECOV: begin
					if (cnt != CNT_ZERO) cnt <= cnt - CNT_W'(1);
					else if (done_s2) state <= DFC_ST_IDLE;
				end
				default: begin
					state <= DFC_ST_IDLE;
					cnt   <= CNT_ZERO;
				end
			endcase
		end
	end

	// Pin drive follows the next state so pins come straight from flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl         <= '{select_n: 1'h1, gate_n: 1'h1, write_n: 1'h1, clear_n: 1'h1, width_word: 1'h1};
			dq_oe_n     <= 1'h1;
			dq_out      <= 16'h0000;
			flash_addr  <= '0;
			accel_level <= 1'h0;
		end else if (state == DFC_ST_IDLE && req_valid) begin
			flash_addr       <= req.addr;
			ctl.width_word   <= !req.byte_mode;
			case (req.op)
				DFC_OP_READ: begin
					ctl.select_n <= 1'h0;
					ctl.gate_n   <= 1'h0;
				end
				DFC_OP_WRITE: begin
					ctl.select_n <= 1'h0;
					ctl.gate_n   <= 1'h1;
					ctl.write_n  <= 1'h0;
					dq_out       <= req.wdata;
					dq_oe_n      <= 1'h0;
					accel_level  <= req.accel;
				end
				default: begin
					ctl.clear_n  <= 1'h0;
					ctl.select_n <= 1'h1;
					ctl.gate_n   <= 1'h1;
				end
			endcase
		end else if (state == DFC_ST_WLOW && cnt == CNT_ZERO) begin
			ctl.write_n <= 1'h1;       // Data held through the high phase
		end else if (state == DFC_ST_CLR && cnt == CNT_ZERO) begin
			ctl.clear_n <= 1'h1;
		end else if ((state == DFC_ST_RD || state == DFC_ST_WHIGH) && cnt == CNT_ZERO) begin
			ctl.select_n <= 1'h1;
			ctl.gate_n   <= 1'h1;
			dq_oe_n      <= 1'h1;
			accel_level  <= 1'h0;
		end
	end

	// Read data capture, ready and clear reporting
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata       <= 16'h0000;
			rdata_valid <= 1'h0;
			req_ready   <= 1'h0;
			clear_redo  <= 1'h0;
			busy_seen   <= 1'h0;
		end else begin
			rdata_valid <= (state == DFC_ST_RD) && (cnt == CNT_ZERO);
			if (state == DFC_ST_RD && cnt == CNT_ZERO) rdata <= dq_s2;
			req_ready   <= (state == DFC_ST_IDLE) && !req_valid ? 1'h1 : 1'h0;
			if (state == DFC_ST_IDLE) busy_seen <= !done_s2;
			clear_redo  <= (state == DFC_ST_CLR) && (cnt == CNT_ZERO) && busy_seen;
		end
	end

	property p_clear_width;
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(ctl.clear_n) |-> !ctl.clear_n [*8];
	endproperty
	a_clear_width: assert property (p_clear_width) else $error("clear pulse too short");

	property p_write_levels;
		@(posedge ref_clk) disable iff (!rst_n)
		!ctl.write_n |-> (!ctl.select_n && ctl.gate_n);
	endproperty
	a_write_levels: assert property (p_write_levels) else $error("write strobe without select or with gate");

	property p_read_wait;
		@(posedge ref_clk) disable iff (!rst_n)
		$fell(ctl.gate_n) |-> !rdata_valid [*8];
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read data taken too early");

	property p_accel_write;
		@(posedge ref_clk) disable iff (!rst_n)
		accel_level |-> (ctl.gate_n && !ctl.select_n);
	endproperty
	a_accel_write: assert property (p_accel_write) else $error("acceleration outside program");

	property p_bus_release;
		@(posedge ref_clk) disable iff (!rst_n)
		ctl.select_n |-> dq_oe_n;
	endproperty
	a_bus_release: assert property (p_bus_release) else $error("data driven while deselected");

	property p_recovery;
		@(posedge ref_clk) disable iff (!rst_n)
		$rose(ctl.clear_n) |-> ctl.select_n [*5];
	endproperty
	a_recovery: assert property (p_recovery) else $error("access before clear recovery");

	property p_width_stable;
		@(posedge ref_clk) disable iff (!rst_n)
		(!ctl.write_n && !$past(ctl.write_n)) |-> $stable(ctl.width_word);
	endproperty
	a_width_stable: assert property (p_width_stable) else $error("width select changed during write");

	property p_idle_standby;
		@(posedge ref_clk) disable iff (!rst_n)
		(state == DFC_ST_IDLE && $past(state) == DFC_ST_IDLE) |-> (ctl.select_n && ctl.clear_n);
	endproperty
	a_idle_standby: assert property (p_idle_standby) else $error("idle without standby levels");

endmodule : dfc_host

/* File: dfc_flash_model.sv */
// Pin-level behavioural model of the dual-bank flash, answering the host controller
module dfc_flash_model
	import dfc_pkg::*;
#(
	parameter int BUSY_CYC = 30
)(
	input  wire logic              ref_clk,
	input  wire dfc_ctl_s          ctl,
	input  wire logic              accel_level,
	input  wire logic [ADDR_W-1:0] flash_addr,
	input  wire logic [DATA_W-1:0] dq_out,
	input  wire logic              dq_oe_n,
	output logic [DATA_W-1:0]      dq_in,
	output logic                   done_flag
);
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] last;
	logic              wr_q;
	int                busy;
	logic [3:0]        idx;

	// bank bit folded into the index
	assign idx = {flash_addr[21], flash_addr[2:0]};
	assign done_flag = (busy == 0);

	// Contents start blank so byte writes leave a known upper byte
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		busy = 0;
		last = 16'h0000;
		wr_q = 1'b1;
	end

	// data driven only when read is legal; released bus shows inverse of last value
	always_comb begin
		if (!dq_oe_n) dq_in = dq_out;
		else if (!ctl.select_n && !ctl.gate_n && ctl.clear_n)
			dq_in = ctl.width_word ? mem[idx] : {~last[15:8], mem[idx][7:0]};
		else dq_in = ~last;
	end

	// Program on the rising write strobe; busy counts the embedded operation
	always @(posedge ref_clk) begin
		wr_q <= ctl.write_n;
		last <= dq_in;
		// clear aborts; busy reloads to 8 only if an operation was running, else stays 0
		if (!ctl.clear_n) busy <= (busy > 0) ? 8 : 0;
		// write cycle needs gate high; accel shortens program time
		else if (ctl.write_n && !wr_q && !ctl.select_n && ctl.gate_n) begin
			if (ctl.width_word) mem[idx] <= dq_out;
			else mem[idx][7:0] <= dq_out[7:0];
			busy <= accel_level ? BUSY_CYC / 2 : BUSY_CYC;
		end
		else if (busy > 0) busy <= busy - 1;
	end
endmodule : dfc_flash_model

/* File: dfc_tb.sv */
// Self-checking bench for the flash host controller against the flash model
module tb
	import dfc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct {dfc_req_s r; logic [15:0] exp;} dfc_row_s;

	logic              ref_clk, rst_n, req_valid, req_ready, rdata_valid, clear_redo;
	logic              accel_level, dq_oe_n, done_flag, redo;
	dfc_req_s          req;
	dfc_ctl_s          ctl;
	logic [DATA_W-1:0] rdata, dq_out, dq_in, d;
	logic [ADDR_W-1:0] flash_addr;
	int                n_errors, samples_checked, ncl;
	dfc_row_s          rows[6];

	dfc_host dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
		.rdata(rdata), .rdata_valid(rdata_valid), .clear_redo(clear_redo), .ctl(ctl), .accel_level(accel_level),
		.flash_addr(flash_addr), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .done_flag(done_flag));
	dfc_flash_model flash (.ref_clk(ref_clk), .ctl(ctl), .accel_level(accel_level), .flash_addr(flash_addr),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in), .done_flag(done_flag));

	// Free-running 100 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	function automatic dfc_req_s mk(dfc_op_e op, logic [21:0] a, logic [15:0] w, logic b, logic acc);
		return '{op: op, addr: a, wdata: w, byte_mode: b, accel: acc};
	endfunction : mk

	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : close_out

	// One request: hand it over, check the pins mid-cycle, wait for idle under a bound
	task automatic run_op(input dfc_req_s r);
		int k;
		redo = 1'b0;
		ncl = 0;
		d = 16'hXXXX;
		@(posedge ref_clk);
		req <= r;
		req_valid <= 1'b1;
		@(posedge ref_clk);
		req_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		#1;
		if (r.op == DFC_OP_WRITE) begin
			chk({ctl.select_n, ctl.write_n, ctl.gate_n, dq_oe_n} === 4'b0010, "write strobes");
			chk(ctl.width_word === !r.byte_mode, "width pin");
			chk(accel_level === r.accel && flash_addr === r.addr, "accel or address");
		end else if (r.op == DFC_OP_READ) begin
			chk({ctl.select_n, ctl.gate_n, ctl.write_n, accel_level} === 4'b0010, "read strobes");
		end else begin
			chk(ctl.clear_n === 1'b0 && ctl.select_n === 1'b1, "clear low");
		end
		for (k = 0; k < 400; k++) begin
			@(posedge ref_clk);
			#1;
			redo |= (clear_redo === 1'b1);
			ncl += (ctl.clear_n === 1'b0);
			// Read data is taken only while its one-cycle valid pulse stands
			if (rdata_valid === 1'b1) d = rdata;
			if (req_ready === 1'b1) break;
		end
		chk(k < 400, "operation hung");
		chk(accel_level === 1'b0, "accel left on");
	endtask : run_op

	// Watchdog sized well above the expected run
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		close_out();
	end

	initial begin
		n_errors = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req = '0;
		rows[0] = '{mk(DFC_OP_WRITE, 22'h000001, 16'hA5C3, 1'b0, 1'b0), 16'h0000};
		rows[1] = '{mk(DFC_OP_WRITE, 22'h200001, 16'h3C5A, 1'b0, 1'b1), 16'h0000};
		rows[2] = '{mk(DFC_OP_READ, 22'h000001, 16'h0000, 1'b0, 1'b0), 16'hA5C3};
		rows[3] = '{mk(DFC_OP_READ, 22'h200001, 16'h0000, 1'b0, 1'b0), 16'h3C5A};
		rows[4] = '{mk(DFC_OP_WRITE, 22'h000002, 16'h00E7, 1'b1, 1'b0), 16'h0000};
		rows[5] = '{mk(DFC_OP_READ, 22'h000002, 16'h0000, 1'b0, 1'b0), 16'h00E7};
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		#1;
		chk({ctl.select_n, ctl.clear_n, ctl.width_word, dq_oe_n, accel_level} === 5'b11110, "reset pins");
		$display("reset test done");
		// Table rows: two writes, a read of the first bank while the second is still busy, a read of the second, then a byte write and its read
		foreach (rows[i]) begin
			run_op(rows[i].r);
			if (rows[i].r.op == DFC_OP_READ) chk(d === rows[i].exp, "read data");
			$display("row %0d done", i);
		end
		// Byte-wide read: only the low byte carries array data
		run_op(mk(DFC_OP_READ, 22'h000002, 16'h0000, 1'b1, 1'b0));
		chk(d[7:0] === 8'hE7 && ctl.width_word === 1'b0, "byte read");
		$display("byte read test done");
		// Clear right after a write, while the flash is busy
		run_op(mk(DFC_OP_WRITE, 22'h000003, 16'h1234, 1'b0, 1'b0));
		run_op(mk(DFC_OP_CLEAR, 22'h000000, 16'h0000, 1'b0, 1'b0));
		chk(redo === 1'b1, "no reissue flag");
		chk(ncl >= CLEAR_CYC - 3, "clear pulse short");
		chk(done_flag === 1'b1, "idle before ready");
		run_op(mk(DFC_OP_READ, 22'h000001, 16'h0000, 1'b0, 1'b0));
		chk(d === 16'hA5C3, "read after clear");
		$display("busy clear test done");
		// Clear when idle, then standby pins and held address
		repeat (40) @(posedge ref_clk);
		run_op(mk(DFC_OP_CLEAR, 22'h000000, 16'h0000, 1'b0, 1'b0));
		chk(redo === 1'b0, "spurious reissue flag");
		run_op(mk(DFC_OP_READ, 22'h200001, 16'h0000, 1'b0, 1'b0));
		repeat (20) @(posedge ref_clk);
		#1;
		chk({ctl.select_n, ctl.clear_n, dq_oe_n} === 3'b111, "standby pins");
		chk(flash_addr === 22'h200001 && d === 16'h3C5A, "address not held");
		$display("idle clear test done");
		close_out();
	end
endmodule : tb
